// ### shared/cdccal_map.svh
// offsets-free constant map for the calibration coefficient block
// assumes inclusion by bare name from design files
`ifndef CDCCAL_MAP_SVH
`define CDCCAL_MAP_SVH
`define CDCCAL_OFFSET_RESET   16'h8000
`define CDCCAL_OFFSET_SE_HINT 16'h3000
`define CDCCAL_ZERO_DIFF      16'h8000
`define CDCCAL_ZERO_SE        16'h0000
`define CDCCAL_FULL_SCALE_FF  4000
`endif

// ### shared/cdccal_pkg.sv
// types for the calibration coefficient block
// assumes no other package
package cdccal_pkg;
	typedef enum logic [1:0] {
		CDCCAL_IDLE,
		CDCCAL_LOAD,
		CDCCAL_RUN
	} cdccal_state_t;
endpackage

// ### hdl/cdccal_core.sv
// gain/offset calibration coefficients and result scaling
// assumes factory gain word held steady by the otp store; one clock
`timescale 1ns/10ps
`include "cdccal_map.svh"
module cdccal_core #(
	parameter int W = 16
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_reset_n,
	input  wire logic [W-1:0] i_otp_gain,
	input  wire logic         i_gain_wr,
	input  wire logic [W-1:0] i_gain_wdata,
	input  wire logic         i_gain_cal,
	input  wire logic         i_offset_wr,
	input  wire logic [W-1:0] i_offset_wdata,
	input  wire logic         i_differential_input_select,
	input  wire logic         i_raw_valid,
	input  wire logic [W-1:0] i_raw,
	output logic      [W-1:0] o_gain,
	output logic      [W-1:0] o_offset,
	output logic              o_loaded,
	output logic              o_differential_input_select,
	output logic              o_result_valid,
	output logic      [W-1:0] o_result
);
	logic rst_s1;
	logic rst_n;
	cdccal_pkg::cdccal_state_t state;
	cdccal_pkg::cdccal_state_t next_state;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// state decode shared by the datapath and the checks below
	function automatic logic cdccal_is_load(
		input cdccal_pkg::cdccal_state_t st
	);
		return st == cdccal_pkg::CDCCAL_LOAD;
	endfunction

	function automatic logic cdccal_is_run(
		input cdccal_pkg::cdccal_state_t st
	);
		return st == cdccal_pkg::CDCCAL_RUN;
	endfunction

	// gain cal takes the full-scale reading as the new gain word;
	// a true ratio against the 4 pF target needs a divider, traded
	// away here for a one-cycle update
	wire           in_load      = cdccal_is_load(state);
	wire           in_run       = cdccal_is_run(state);
	// writes before the factory load are dropped without notice
	wire           gain_wr_take = i_gain_wr && in_run;
	wire           cal_hit      = i_gain_cal && i_raw_valid;
	// a host write wins over a calibration hit in the same cycle
	wire           cal_take     = cal_hit && in_run && !i_gain_wr;
	wire           offset_take  = i_offset_wr && in_run;
	wire           result_take  = i_raw_valid && !i_gain_cal && in_run;
	// offset sum cut to W bits on purpose: it wraps like the raw code
	wire [W-1:0]   corrected    = W'(i_raw + o_offset
	                                 - W'(`CDCCAL_ZERO_DIFF));
	wire [2*W-1:0] prod         = (2*W)'(corrected) * (2*W)'(o_gain);
	// gain 0x8000 is unity, so the product is taken from bit 15 up
	wire [W-1:0]   scaled       = prod[2*W-2:W-1];

	always_comb begin
		next_state = state;
		case (state)
			cdccal_pkg::CDCCAL_IDLE: next_state = cdccal_pkg::CDCCAL_LOAD;
			cdccal_pkg::CDCCAL_LOAD: next_state = cdccal_pkg::CDCCAL_RUN;
			cdccal_pkg::CDCCAL_RUN:  next_state = cdccal_pkg::CDCCAL_RUN;
			default:                 next_state = cdccal_pkg::CDCCAL_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state    <= cdccal_pkg::CDCCAL_IDLE;
			o_gain   <= '0;
			o_offset <= W'(`CDCCAL_OFFSET_RESET);
			o_loaded <= 1'b0;
		end else begin
			state <= next_state;
			if (in_load) begin
				o_gain   <= i_otp_gain;
				o_loaded <= 1'b1;
			end else if (gain_wr_take) begin
				o_gain <= i_gain_wdata;
			end else if (cal_take) begin
				o_gain <= i_raw;
			end
			// any 16-bit value accepted, full range
			if (offset_take)
				o_offset <= i_offset_wdata;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_result_valid              <= 1'b0;
			o_result                    <= '0;
			o_differential_input_select <= 1'b0;
		end else begin
			o_differential_input_select <= i_differential_input_select;
			o_result_valid <= result_take;
			if (i_raw_valid)
				o_result <= scaled;
		end
	end

	AST_OFFSET_DEFAULT: assert property (@(posedge i_clk_sys)
		$rose(rst_n) |-> o_offset == `CDCCAL_OFFSET_RESET)
		else $error("offset not at default after reset");
	AST_GAIN_LOAD: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		state == cdccal_pkg::CDCCAL_LOAD |=> o_gain == $past(i_otp_gain))
		else $error("factory gain not loaded");
	AST_GAIN_WRITE: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		state == cdccal_pkg::CDCCAL_RUN && i_gain_wr
		|=> o_gain == $past(i_gain_wdata))
		else $error("gain write lost");
	AST_OFFSET_WRITE: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		state == cdccal_pkg::CDCCAL_RUN && i_offset_wr
		|=> o_offset == $past(i_offset_wdata))
		else $error("offset write lost");
	AST_RESULT_SCALED: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		i_raw_valid |=> o_result == $past(scaled))
		else $error("result not scaled");
	AST_LOADED_TWO: assert property (@(posedge i_clk_sys)
		$rose(rst_n) |-> !o_loaded ##2 o_loaded)
		else $error("load timing wrong");

	// checks below hold only once the internal reset has let go
	AST_OFFSET_HOLD: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		!(i_offset_wr && in_run) |=> $stable(o_offset))
		else $error("offset moved without a write");

	AST_IDLE_DEFAULTS: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		state == cdccal_pkg::CDCCAL_IDLE
		|=> o_gain == '0 && o_offset == W'(`CDCCAL_OFFSET_RESET))
		else $error("early write reached a coefficient");

	AST_GAIN_CAL: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		in_run && i_gain_cal && i_raw_valid && !i_gain_wr
		|=> o_gain == $past(i_raw))
		else $error("calibration reading not taken as gain");

	AST_GAIN_HOLD: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		in_run && !i_gain_wr && !(i_gain_cal && i_raw_valid)
		|=> $stable(o_gain))
		else $error("gain moved without a write or calibration");

	AST_LOAD_TO_RUN: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		in_load |=> in_run && o_loaded)
		else $error("factory load did not complete");

	AST_LOADED_STAYS: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		o_loaded |=> o_loaded)
		else $error("loaded flag dropped without reset");

	// no result is flagged valid while calibration owns the reading; o_result still takes the scaled word
	AST_VALID_CAL: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		i_gain_cal |=> !o_result_valid)
		else $error("result flagged during calibration");

	AST_VALID_RAW: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		in_run && i_raw_valid && !i_gain_cal |=> o_result_valid)
		else $error("result not flagged");

	AST_RESULT_HOLD: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		!i_raw_valid |=> $stable(o_result))
		else $error("result changed without a new reading");

	// unity gain and default offset must pass the raw word through
	AST_UNITY_GAIN: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		i_raw_valid && o_gain == W'(16'h8000)
		&& o_offset == W'(`CDCCAL_OFFSET_RESET)
		|=> o_result == $past(i_raw))
		else $error("unity scaling altered the reading");

	AST_DSEL_COPY: assert property (@(posedge i_clk_sys)
		disable iff (!rst_n)
		1'b1 |=> o_differential_input_select
		== $past(i_differential_input_select))
		else $error("mode bit copy lost");
endmodule

// ### tb/cdccal_host.sv
// host model: keeps the calibrated offset and writes it back on request
// assumes i_go is a one-cycle pulse from the bench
`timescale 1ns/10ps
module cdccal_host (
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic [15:0] i_value,
	output logic             o_offset_wr,
	output logic [15:0]      o_offset_wdata
);
	logic [15:0] kept = 16'h8000;
	initial {o_offset_wr, o_offset_wdata} = 17'h00000;
	always @(posedge i_clk) begin
		kept <= i_value;
		o_offset_wr <= i_go;
		// idle data flips so a stale word is never mistaken for a write
		o_offset_wdata <= i_go ? kept : ~o_offset_wdata;
	end
endmodule

// ### tb/cdc_calibration_coefficients_tb.sv
// bench: calibration block fed by a host model
// assumes one 250 MHz clock, no bus
`timescale 1ns/10ps
module cdc_calibration_coefficients_tb;
	logic        clk = 0, rst_n = 0, gwr = 0, cal = 0, rv = 0, go = 0, md = 1;
	logic [15:0] gd = 0, raw = 0, ov = 16'hA000, otp = 16'h8000, g, o, r, od;
	logic        ld, dsel, vld, owr;
	int          err_total = 0, checks_done = 0, cyc = 0;
	always #2 clk = ~clk;
	always @(posedge clk) if (++cyc > 900) print_verdict(1);
	cdccal_core u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_otp_gain(otp),
		.i_gain_wr(gwr), .i_gain_wdata(gd), .i_gain_cal(cal), .i_raw(raw),
		.i_offset_wr(owr), .i_offset_wdata(od), .i_raw_valid(rv),
		.i_differential_input_select(md), .o_gain(g), .o_offset(o),
		.o_loaded(ld), .o_differential_input_select(dsel),
		.o_result_valid(vld), .o_result(r));
	cdccal_host u_host (.i_clk(clk), .i_go(go), .i_value(ov),
		.o_offset_wr(owr), .o_offset_wdata(od));
	task chk(input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task print_verdict(input bit hang);
		err_total += hang;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task t_reset;
		rst_n <= 0;
		repeat (12) @(posedge clk);
		rst_n <= 1;
		while (ld !== 1) @(posedge clk);
		@(posedge clk) #1;
		chk(g, otp);
		chk(o, 16'h8000);
		chk({15'h0000, ld}, 16'h0001);
		@(posedge clk) raw <= 16'h1234;
		rv <= 1;
		@(posedge clk) rv <= 0;
		#1 chk(r, 16'h1234);
		$display("reset test done");
	endtask
	task t_run;
		@(posedge clk) go <= 1;
		@(posedge clk) go <= 0;
		gwr <= 1;
		gd <= 16'h4000;
		md <= 0;
		@(posedge clk) gwr <= 0;
		@(posedge clk) raw <= 16'h4000;
		rv <= 1;
		@(posedge clk) rv <= 0;
		#1 chk({15'h0000, vld}, 16'h0001);
		chk(r, 16'h3000);
		chk(g, 16'h4000);
		chk(o, 16'hA000);
		chk({15'h0000, dsel}, 16'h0000);
		// calibration takes the full-scale reading as the new gain
		@(posedge clk) cal <= 1;
		raw <= 16'h7000;
		rv <= 1;
		@(posedge clk) rv <= 0;
		cal <= 0;
		#1 chk({15'h0000, vld}, 16'h0000);
		@(posedge clk) #1 chk(g, 16'h7000);
		$display("run test done");
	endtask
	initial begin
		t_reset;
		t_run;
		t_reset;
		print_verdict(0);
	end
endmodule
